//--- core/pbafm_core.sv
// port b override logic: resolves pin direction, value, pull-up and input enable
// assumes all peripheral signals on CLOCK; pin levels arrive asynchronously
`timescale 1ns/10ps
module pbafm_core (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire pbafm_pkg::pbafm_vec_t PIN_LEVEL,
   input wire pbafm_pkg::pbafm_vec_t DIR_REG,
   input wire pbafm_pkg::pbafm_vec_t OUT_REG,
   input wire logic GLOBAL_PULLUP_DISABLE,
   input wire logic SLEEP_CLAMP,
   input wire logic SPI_ENABLE_BIT,
   input wire logic SPI_MASTER_SELECT,
   input wire logic SPI_PIN_SELECT,
   input wire logic INTERNAL_RESET_SIGNAL,
   input wire logic SPI_CLOCK_OUT,
   input wire logic SPI_MOSI_OUT,
   input wire logic SPI_MISO_OUT,
   input wire logic PWM_STAGE_ENABLE_0B,
   input wire logic PWM_STAGE_VALUE_0B,
   input wire logic PWM_STAGE_ENABLE_1B,
   input wire logic PWM_STAGE_VALUE_1B,
   input wire logic PWM_STAGE_ENABLE_2B,
   input wire logic PWM_STAGE_VALUE_2B,
   input wire logic PWM_STAGE_ENABLE_2A,
   input wire logic PWM_STAGE_VALUE_2A,
   input wire logic EXT_IRQ1_ENABLE,
   input wire logic EXT_IRQ2_ENABLE,
   input wire logic ANALOG4_INPUT_DISABLE,
   input wire logic ANALOG5_INPUT_DISABLE,
   input wire logic ANALOG6_INPUT_DISABLE,
   input wire logic ANALOG7_INPUT_DISABLE,
   input wire logic AMPLIFIER0_INPUT_DISABLE,
   output pbafm_pkg::pbafm_vec_t PIN_OUT,
   output pbafm_pkg::pbafm_vec_t PIN_OE,
   output pbafm_pkg::pbafm_vec_t PIN_PULLUP,
   output pbafm_pkg::pbafm_vec_t PIN_INPUT_ENABLE,
   output pbafm_pkg::pbafm_vec_t PIN_READ,
   output pbafm_pkg::pbafm_vec_t PIN_CHANGE_IRQ,
   output logic EXT_IRQ_SOURCE_1,
   output logic EXT_IRQ_SOURCE_2,
   output logic SPI_CLOCK_INPUT,
   output logic SPI_MOSI_IN,
   output logic SPI_MISO_IN
);
   import pbafm_pkg::*;

   // pull-up from override, else input with output bit set and pull-ups allowed
   function automatic logic resolve_pullup(input logic oe, input logic ov, input logic dd,
                                           input logic po, input logic global_pullup_disable);
      resolve_pullup = oe ? ov : ({dd, po, global_pullup_disable} == PULLUP_PATTERN);
   endfunction : resolve_pullup

   function automatic logic resolve_override(input logic oe, input logic ov, input logic dflt);
      resolve_override = oe ? ov : dflt;
   endfunction : resolve_override

   // two-stage synchroniser on the pad levels
   pbafm_vec_t sync_a;
   pbafm_vec_t sync_b;

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync_a <= RESET_VEC;
         sync_b <= RESET_VEC;
      end else begin
         sync_a <= PIN_LEVEL;
         sync_b <= sync_a;
      end
   end

   // spi owns the port b pins only when its pin select is low
   logic spi_here;
   logic spi_slave;
   logic spi_master;
   assign spi_here = SPI_ENABLE_BIT & ~SPI_PIN_SELECT;
   assign spi_slave = spi_here & ~SPI_MASTER_SELECT;
   assign spi_master = spi_here & SPI_MASTER_SELECT;

   pbafm_vec_t pullup_override_enable;
   pbafm_vec_t pullup_override_value;
   pbafm_vec_t direction_override_enable;
   pbafm_vec_t direction_override_value;
   pbafm_vec_t value_override_enable;
   pbafm_vec_t value_override_value;
   pbafm_vec_t input_enable_override_enable;
   pbafm_vec_t input_enable_override_value;

   always_comb begin
      pullup_override_enable = RESET_VEC;
      pullup_override_value = RESET_VEC;
      direction_override_enable = RESET_VEC;
      direction_override_value = RESET_VEC;
      value_override_enable = RESET_VEC;
      value_override_value = RESET_VEC;
      input_enable_override_enable = RESET_VEC;
      input_enable_override_value = RESET_VEC;
      // clock pin: slave forces input, master keeps direction bit
      pullup_override_enable[PIN_SCK] = spi_slave;
      pullup_override_value[PIN_SCK] = OUT_REG[PIN_SCK] & ~GLOBAL_PULLUP_DISABLE;
      direction_override_enable[PIN_SCK] = spi_slave | PWM_STAGE_ENABLE_0B;
      direction_override_value[PIN_SCK] = PWM_STAGE_ENABLE_0B;
      value_override_enable[PIN_SCK] = spi_master | PWM_STAGE_ENABLE_0B;
      value_override_value[PIN_SCK] = PWM_STAGE_ENABLE_0B ? PWM_STAGE_VALUE_0B : SPI_CLOCK_OUT;
      input_enable_override_enable[PIN_SCK] = ANALOG4_INPUT_DISABLE;
      // pwm output 1b
      direction_override_enable[PIN_PWM_1B] = PWM_STAGE_ENABLE_1B;
      direction_override_value[PIN_PWM_1B] = 1'b1;
      value_override_enable[PIN_PWM_1B] = PWM_STAGE_ENABLE_1B;
      value_override_value[PIN_PWM_1B] = PWM_STAGE_VALUE_1B;
      input_enable_override_enable[PIN_PWM_1B] = ANALOG7_INPUT_DISABLE;
      // external irq 2 keeps input alive over analog disable and sleep
      input_enable_override_enable[PIN_IRQ2] = ANALOG6_INPUT_DISABLE | EXT_IRQ2_ENABLE;
      input_enable_override_value[PIN_IRQ2] = EXT_IRQ2_ENABLE;
      input_enable_override_enable[PIN_AMP_POS] = AMPLIFIER0_INPUT_DISABLE;
      input_enable_override_enable[PIN_AMP_NEG] = AMPLIFIER0_INPUT_DISABLE;
      input_enable_override_enable[PIN_IRQ1] = ANALOG5_INPUT_DISABLE | EXT_IRQ1_ENABLE;
      input_enable_override_value[PIN_IRQ1] = EXT_IRQ1_ENABLE;
      // mosi: slave forces input
      pullup_override_enable[PIN_MOSI] = spi_slave;
      pullup_override_value[PIN_MOSI] = OUT_REG[PIN_MOSI] & ~GLOBAL_PULLUP_DISABLE;
      direction_override_enable[PIN_MOSI] = spi_slave | PWM_STAGE_ENABLE_2B;
      direction_override_value[PIN_MOSI] = PWM_STAGE_ENABLE_2B;
      value_override_enable[PIN_MOSI] = spi_master | PWM_STAGE_ENABLE_2B;
      value_override_value[PIN_MOSI] = PWM_STAGE_ENABLE_2B ? PWM_STAGE_VALUE_2B : SPI_MOSI_OUT;
      // miso: master forces input
      pullup_override_enable[PIN_MISO] = spi_master;
      pullup_override_value[PIN_MISO] = OUT_REG[PIN_MISO] & ~GLOBAL_PULLUP_DISABLE;
      direction_override_enable[PIN_MISO] = spi_master | PWM_STAGE_ENABLE_2A;
      direction_override_value[PIN_MISO] = PWM_STAGE_ENABLE_2A;
      value_override_enable[PIN_MISO] = spi_slave | PWM_STAGE_ENABLE_2A;
      value_override_value[PIN_MISO] = PWM_STAGE_ENABLE_2A ? PWM_STAGE_VALUE_2A : SPI_MISO_OUT;
   end

   pbafm_vec_t next_oe;
   pbafm_vec_t next_out;
   pbafm_vec_t next_pullup;
   pbafm_vec_t next_in_en;

   always_comb begin
      next_oe = RESET_VEC;
      next_out = RESET_VEC;
      next_pullup = RESET_VEC;
      next_in_en = RESET_VEC;
      // sleep clamps every input that no function keeps alive
      for (int i = 0; i < PORT_WIDTH; i++) begin
         next_oe[i] = resolve_override(direction_override_enable[i], direction_override_value[i], DIR_REG[i]);
         next_out[i] = next_oe[i] & resolve_override(value_override_enable[i], value_override_value[i], OUT_REG[i]);
         next_pullup[i] = resolve_pullup(pullup_override_enable[i], pullup_override_value[i], DIR_REG[i], OUT_REG[i],
                                         GLOBAL_PULLUP_DISABLE);
         next_in_en[i] = resolve_override(input_enable_override_enable[i], input_enable_override_value[i], ~SLEEP_CLAMP);
      end
   end

   // input clamped to low while the input buffer is disabled
   pbafm_vec_t pin_in;
   assign pin_in = sync_b & next_in_en;

   // pad controls registered so no pad glitches while the controls settle
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         PIN_OE <= RESET_VEC;
         PIN_OUT <= RESET_VEC;
         PIN_PULLUP <= RESET_VEC;
         PIN_INPUT_ENABLE <= RESET_VEC;
      end else begin
         PIN_OE <= next_oe;
         PIN_OUT <= next_out;
         PIN_PULLUP <= next_pullup;
         PIN_INPUT_ENABLE <= next_in_en;
      end
   end

   // reads and irq sources share the gated, synchronised level
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         PIN_READ <= RESET_VEC;
         PIN_CHANGE_IRQ <= RESET_VEC;
         EXT_IRQ_SOURCE_1 <= RESET_BIT;
         EXT_IRQ_SOURCE_2 <= RESET_BIT;
      end else begin
         PIN_READ <= pin_in;
         PIN_CHANGE_IRQ <= pin_in;
         EXT_IRQ_SOURCE_1 <= pin_in[PIN_IRQ1];
         EXT_IRQ_SOURCE_2 <= pin_in[PIN_IRQ2];
      end
   end

   // spi sees nothing while routed elsewhere or held in internal reset
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         SPI_CLOCK_INPUT <= RESET_BIT;
         SPI_MOSI_IN <= RESET_BIT;
         SPI_MISO_IN <= RESET_BIT;
      end else begin
         SPI_CLOCK_INPUT <= pin_in[PIN_SCK] & ~SPI_PIN_SELECT & ~INTERNAL_RESET_SIGNAL;
         SPI_MOSI_IN <= pin_in[PIN_MOSI] & ~SPI_PIN_SELECT & ~INTERNAL_RESET_SIGNAL;
         SPI_MISO_IN <= pin_in[PIN_MISO] & ~SPI_PIN_SELECT & ~INTERNAL_RESET_SIGNAL;
      end
   end
endmodule : pbafm_core

//--- core/pbafm_pkg.sv
// constants for the port b alternate function override logic
// assumes one i/o clock and an active-low asynchronous reset
package pbafm_pkg;
   localparam int PORT_WIDTH = 8;
   typedef logic [PORT_WIDTH-1:0] pbafm_vec_t;

   // pin positions of the alternate functions
   localparam int PIN_SCK = 7;
   localparam int PIN_PWM_1B = 6;
   localparam int PIN_IRQ2 = 5;
   localparam int PIN_AMP_POS = 4;
   localparam int PIN_AMP_NEG = 3;
   localparam int PIN_IRQ1 = 2;
   localparam int PIN_MOSI = 1;
   localparam int PIN_MISO = 0;

   // default pull-up pattern of {direction, output, pull-up disable}
   localparam logic [2:0] PULLUP_PATTERN = 3'h2;

   // values after reset
   localparam pbafm_vec_t RESET_VEC = 8'h00;
   localparam logic RESET_BIT = 1'b0;
   localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage : pbafm_pkg

//--- dv/pbafm_assertions.sv
// checks of the port b override core outputs
// bound to pbafm_core; one clock, async low reset
`timescale 1ns/10ps
module pbafm_assertions (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic GLOBAL_PULLUP_DISABLE,
   input wire logic SPI_ENABLE_BIT,
   input wire logic SPI_MASTER_SELECT,
   input wire logic SPI_PIN_SELECT,
   input wire logic PWM_STAGE_ENABLE_0B,
   input wire logic PWM_STAGE_ENABLE_1B,
   input wire logic PWM_STAGE_VALUE_1B,
   input wire logic PWM_STAGE_ENABLE_2B,
   input wire logic PWM_STAGE_ENABLE_2A,
   input wire logic EXT_IRQ2_ENABLE,
   input wire pbafm_pkg::pbafm_vec_t DIR_REG,
   input wire pbafm_pkg::pbafm_vec_t OUT_REG,
   input wire pbafm_pkg::pbafm_vec_t PIN_OE,
   input wire pbafm_pkg::pbafm_vec_t PIN_OUT,
   input wire pbafm_pkg::pbafm_vec_t PIN_PULLUP,
   input wire pbafm_pkg::pbafm_vec_t PIN_INPUT_ENABLE
);
   import pbafm_pkg::*;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   sequence s_slave; SPI_ENABLE_BIT && !SPI_PIN_SELECT && !SPI_MASTER_SELECT; endsequence
   sequence s_master; SPI_ENABLE_BIT && !SPI_PIN_SELECT && SPI_MASTER_SELECT; endsequence
   property p_sck_in; s_slave ##0 !PWM_STAGE_ENABLE_0B |=> !PIN_OE[7]; endproperty
   a_sck_in: assert property (p_sck_in) else $error("sck driven as slave");
   property p_mosi_in; s_slave ##0 !PWM_STAGE_ENABLE_2B |=> !PIN_OE[1]; endproperty
   a_mosi_in: assert property (p_mosi_in) else $error("mosi driven as slave");
   property p_miso_in; s_master ##0 !PWM_STAGE_ENABLE_2A |=> !PIN_OE[0]; endproperty
   a_miso_in: assert property (p_miso_in) else $error("miso driven as master");
   property p_sck_dir;
      s_master ##0 !PWM_STAGE_ENABLE_0B |=> PIN_OE[7] == $past(DIR_REG[7]);
   endproperty
   a_sck_dir: assert property (p_sck_dir) else $error("sck direction wrong");
   property p_sck_pu;
      s_slave |=> PIN_PULLUP[7] == ($past(OUT_REG[7]) && !$past(GLOBAL_PULLUP_DISABLE));
   endproperty
   a_sck_pu: assert property (p_sck_pu) else $error("sck pull-up wrong");
   property p_pwm6; PWM_STAGE_ENABLE_1B |=> PIN_OE[6] && PIN_OUT[6] == $past(PWM_STAGE_VALUE_1B);
   endproperty
   a_pwm6: assert property (p_pwm6) else $error("pin 6 pwm wrong");
   property p_irq2; EXT_IRQ2_ENABLE |=> PIN_INPUT_ENABLE[5]; endproperty
   a_irq2: assert property (p_irq2) else $error("pin 5 input off");
   property p_dir3; 1'b1 |=> PIN_OE[3] == $past(DIR_REG[3]); endproperty
   a_dir3: assert property (p_dir3) else $error("pin 3 direction wrong");
   property p_pu4; 1'b1 |=> PIN_PULLUP[4] ==
      ({$past(DIR_REG[4]), $past(OUT_REG[4]), $past(GLOBAL_PULLUP_DISABLE)} == PULLUP_PATTERN);
   endproperty
   a_pu4: assert property (p_pu4) else $error("pin 4 pull-up wrong");
   property p_off; (PIN_OUT & ~PIN_OE) == 8'h00; endproperty
   a_off: assert property (p_off) else $error("value on undriven pin");
endmodule : pbafm_assertions
bind pbafm_core pbafm_assertions u_chk (
   .CLOCK(CLOCK),
   .ARST_N(ARST_N),
   .GLOBAL_PULLUP_DISABLE(GLOBAL_PULLUP_DISABLE),
   .SPI_ENABLE_BIT(SPI_ENABLE_BIT),
   .SPI_MASTER_SELECT(SPI_MASTER_SELECT),
   .SPI_PIN_SELECT(SPI_PIN_SELECT),
   .PWM_STAGE_ENABLE_0B(PWM_STAGE_ENABLE_0B),
   .PWM_STAGE_ENABLE_1B(PWM_STAGE_ENABLE_1B),
   .PWM_STAGE_VALUE_1B(PWM_STAGE_VALUE_1B),
   .PWM_STAGE_ENABLE_2B(PWM_STAGE_ENABLE_2B),
   .PWM_STAGE_ENABLE_2A(PWM_STAGE_ENABLE_2A),
   .EXT_IRQ2_ENABLE(EXT_IRQ2_ENABLE),
   .DIR_REG(DIR_REG),
   .OUT_REG(OUT_REG),
   .PIN_OE(PIN_OE),
   .PIN_OUT(PIN_OUT),
   .PIN_PULLUP(PIN_PULLUP),
   .PIN_INPUT_ENABLE(PIN_INPUT_ENABLE)
);

//--- dv/pbafm_pad_model.sv
// pad model: pin level from driver, outside drive and pull-up
// assumes the bench moves xen and xval on falling edges
`timescale 1ns/10ps
module pbafm_pad_model (
   input wire logic clock,
   input wire pbafm_pkg::pbafm_vec_t oe,
   input wire pbafm_pkg::pbafm_vec_t out,
   input wire pbafm_pkg::pbafm_vec_t pull,
   input wire pbafm_pkg::pbafm_vec_t xen,
   input wire pbafm_pkg::pbafm_vec_t xval,
   output pbafm_pkg::pbafm_vec_t level
);
   import pbafm_pkg::*;
   pbafm_vec_t drift = 8'h55;
   // undriven pins without pull-up wander
   always_ff @(posedge clock) drift <= ~drift;
   assign level = (oe & out) | (~oe & xen & xval) | (~oe & ~xen & (pull | drift));
endmodule : pbafm_pad_model

//--- dv/tb_pbafm_core.sv
// bench for the port b override core
// pads come from the pad model; inputs move on falling edges
`timescale 1ns/10ps
module tb_pbafm_core;
   logic clk = 1'b0, rst_n = 1'b0, e1, e2, sck, mosi, miso;
   logic [23:0] c = 24'h00_0000;
   pbafm_pkg::pbafm_vec_t dir = 8'h00, outr = 8'h00, xen = 8'h00, xval = 8'h00;
   pbafm_pkg::pbafm_vec_t lvl, oe, po, pu, ie, rd, pc;
   int n_fail = 0, n_tests = 0;
   always #2.5 clk = ~clk;
   pbafm_core dut (.CLOCK(clk), .ARST_N(rst_n), .PIN_LEVEL(lvl), .DIR_REG(dir), .OUT_REG(outr),
      .GLOBAL_PULLUP_DISABLE(c[0]), .SLEEP_CLAMP(c[1]), .SPI_ENABLE_BIT(c[2]),
      .SPI_MASTER_SELECT(c[3]), .SPI_PIN_SELECT(c[4]), .INTERNAL_RESET_SIGNAL(c[5]),
      .SPI_CLOCK_OUT(c[6]), .SPI_MOSI_OUT(c[7]), .SPI_MISO_OUT(c[8]),
      .PWM_STAGE_ENABLE_0B(c[9]), .PWM_STAGE_VALUE_0B(c[10]), .PWM_STAGE_ENABLE_1B(c[11]),
      .PWM_STAGE_VALUE_1B(c[12]), .PWM_STAGE_ENABLE_2B(c[13]), .PWM_STAGE_VALUE_2B(c[14]),
      .PWM_STAGE_ENABLE_2A(c[15]), .PWM_STAGE_VALUE_2A(c[16]), .EXT_IRQ1_ENABLE(c[17]),
      .EXT_IRQ2_ENABLE(c[18]), .ANALOG4_INPUT_DISABLE(c[19]), .ANALOG5_INPUT_DISABLE(c[20]),
      .ANALOG6_INPUT_DISABLE(c[21]), .ANALOG7_INPUT_DISABLE(c[22]),
      .AMPLIFIER0_INPUT_DISABLE(c[23]), .PIN_OUT(po), .PIN_OE(oe), .PIN_PULLUP(pu),
      .PIN_INPUT_ENABLE(ie), .PIN_READ(rd), .PIN_CHANGE_IRQ(pc), .EXT_IRQ_SOURCE_1(e1),
      .EXT_IRQ_SOURCE_2(e2), .SPI_CLOCK_INPUT(sck), .SPI_MOSI_IN(mosi), .SPI_MISO_IN(miso));
   pbafm_pad_model pads (.clock(clk), .oe(oe), .out(po), .pull(pu), .xen(xen), .xval(xval),
      .level(lvl));
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_tests++;
      n_fail += int'(got !== exp);
      if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
   endtask : chk
   // control word bits follow the dut port order above
   task automatic drive(input logic [23:0] ctl, input logic [15:0] d_o, input int n);
      {c, dir, outr} = {ctl, d_o};
      repeat (n) @(negedge clk);
   endtask : drive
   task automatic t_gpio;
      drive(24'h00_0000, 16'h0F33, 1);
      chk("gpio", 32'({oe, po, pu}), 32'h000F_0330);
   endtask : t_gpio
   task automatic t_spi;
      drive(24'h00_0104, 16'hFF83, 1);
      chk("slave", 32'({oe, po, pu}), 32'h007D_0182);
      drive(24'h00_0105, 16'hFF83, 1);
      chk("slave pud", 32'(pu), 32'h0000_0000);
      drive(24'h00_004C, 16'h8201, 1);
      chk("master", 32'({oe, po, pu}), 32'h0082_8001);
      drive(24'h00_0014, 16'hFF83, 1);
      chk("spi moved", 32'({oe, po, pu}), 32'h00FF_8300);
   endtask : t_spi
   task automatic t_pwm;
      drive(24'h01_AE04, 16'h0000, 1);
      chk("pwm", 32'({oe, po}), 32'h0000_C381);
      drive(24'h00_FA04, 16'h0000, 1);
      chk("pwm flip", 32'({oe, po}), 32'h0000_C342);
   endtask : t_pwm
   task automatic t_pins;
      {xen, xval} = 16'hFFFF;
      drive(24'h06_0002, 16'h0000, 4);
      chk("irq", {ie, rd, pc, 6'h00, e2, e1}, 32'h2424_2403);
      xval = 8'h5A;
      drive(24'hF8_0000, 16'h0000, 4);
      chk("analog", 32'({ie, rd, pc}), 32'h0003_0202);
      xval = 8'h83;
      drive(24'h00_0000, 16'h0000, 4);
      chk("spi in", 32'({sck, mosi, miso}), 32'h0000_0007);
      drive(24'h00_0020, 16'h0000, 1);
      chk("spi gated", 32'({sck, mosi, miso}), 32'h0000_0000);
      drive(24'h00_0000, 16'h0000, 1);
      chk("spi back", 32'({sck, mosi, miso}), 32'h0000_0007);
      drive(24'h00_0010, 16'h0000, 1);
      chk("spi elsewhere", 32'({sck, mosi, miso}), 32'h0000_0000);
   endtask : t_pins
   task automatic end_of_test;
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      t_gpio;
      t_spi;
      t_pwm;
      t_pins;
      end_of_test;
   end
   initial begin
      #2500 n_fail++;
      end_of_test;
   end
endmodule : tb_pbafm_core
